// ### dv/fps_flash_model.sv
`timescale 1ns/1ps
module fps_flash_model #(
  parameter logic [7:0] CMD_SUSP = 8'hb5, // Same opcodes as the host defaults
  parameter logic [7:0] CMD_RES = 8'hd0,
  parameter logic [7:0] CMD_LOCK = 8'h60,
  parameter logic [7:0] CMD_BLK = 8'h01,
  parameter logic [7:0] CMD_PERM = 8'hf1,
  parameter logic [7:0] CMD_CLR = 8'hd0,
  parameter int PROG_TICKS = 400
) (
  // Host pins
  input fps_pkg::fps_pins_t pins,
  input wire logic supply_low,
  // Device outputs
  output logic [15:0] dq,
  output logic ready_busy_output
);
  logic [7:0] sr = 8'h80;
  logic [7:0] last_setup = 8'h00;
  logic blk = 1'b0;
  logic perm = 1'b0; // No path ever clears it
  logic sreq = 1'b0;
  int rem = 0;
  int pend = 0;
  int prog_cnt = 0;
  wire boot = pins.addr[19:16] == 4'hf;
  // Commands latch on the rising write strobe; ce_n rises with it, so it is not looked at
  always @(posedge pins.we_n) begin
    logic [7:0] c;
    c = pins.dq_out[7:0];
    if (pend == 1) begin
      pend = 0;
      if (supply_low) sr = sr | 8'h18;
      else if (boot && (!pins.wp_n || blk)) sr = sr | 8'h12;
      else begin
        rem = PROG_TICKS;
        sr[7] = 1'b0;
        prog_cnt++;
      end
    end else if (pend == 2) begin
      pend = 0;
      if (c != CMD_BLK && c != CMD_PERM && c != CMD_CLR) sr = sr | 8'h30;
      else if (c == CMD_CLR && perm) sr = sr | 8'h22;
      else if (c == CMD_CLR && supply_low) sr = sr | 8'h28;
      else if (c == CMD_CLR) blk = 1'b0;
      else if (perm) sr = sr | 8'h12;
      else if (c == CMD_BLK) blk = 1'b1;
      else perm = 1'b1;
    end else if (c == 8'h40 || c == 8'h10) begin
      pend = 1;
      last_setup = c;
    end else if (c == CMD_LOCK) pend = 2;
    else if (c == 8'h50 && !sr[2] && !sr[6]) sr = sr & 8'hc4;
    else if (c == CMD_SUSP) sreq = rem > 0; // Finished work is not suspended
    else if (c == CMD_RES && sr[2]) sr = sr & 8'h7b;
  end
  // Algorithm runs on its own time base, frozen while suspended
  always #5 if (rem > 0 && !sr[2]) begin
    if (sreq) begin
      sr = sr | 8'h84;
      sreq = 1'b0;
    end else begin
      rem--;
      sr[7] = rem == 0;
    end
  end
  // Reads give status; a released bus shows the inverse so stale data never matches
  assign dq = (!pins.ce_n && !pins.oe_n) ? {8'h00, sr} : ~{8'h00, sr};
  // Low only while running; driven high otherwise, suspended included
  assign ready_busy_output = !(rem > 0 && !sr[2]);
endmodule

// ### dv/fps_host_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Pin and bus checks
// ****************************************
module fps_host_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash pins
  input fps_pkg::fps_pins_t flash_o
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and map decode
  wire acc = psel && penable;
  wire mapped = paddr <= 8'h14 && paddr[1:0] == 2'b00;

  a_apb_ready: assert property (acc |-> pready) else $error("access not answered");
  a_bad_offset: assert property (acc |-> pslverr == !mapped) else $error("slave error wrong");
  a_idle_rdata: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read");
  a_reset_pins: assert property ($rose(presetn) |-> flash_o.ce_n && flash_o.we_n
    && flash_o.oe_n && !flash_o.dq_oe) else $error("pins active out of reset");
  a_we_width: assert property ($fell(flash_o.we_n) |-> ##14 !flash_o.we_n ##1 flash_o.we_n)
    else $error("write strobe width wrong");
  a_we_recover: assert property ($rose(flash_o.we_n) |->
    (flash_o.we_n && flash_o.dq_oe && $stable(flash_o.dq_out))[*8]) else $error("data hold short");
  a_we_steady: assert property (!flash_o.we_n && !$past(flash_o.we_n) |->
    $stable(flash_o.addr) && $stable(flash_o.dq_out)) else $error("bus moved in strobe");
  a_oe_width: assert property ($fell(flash_o.oe_n) |-> ##26 !flash_o.oe_n ##1 flash_o.oe_n)
    else $error("read strobe width wrong");
  a_no_fight: assert property (!flash_o.oe_n |-> !flash_o.dq_oe && flash_o.we_n)
    else $error("bus contention");
  a_strobe_chip: assert property (!flash_o.we_n || !flash_o.oe_n |-> !flash_o.ce_n)
    else $error("strobe without chip enable");
endmodule

bind fps_host fps_host_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flash_o(flash_o));

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, supply_low = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, st;
  wire [31:0] prdata;
  wire pready, pslverr, ryby;
  wire [15:0] dq_dev, dq_in;
  fps_pkg::fps_pins_t pins;
  int n_mismatch = 0, comparisons = 0, seed = 32'hced0cded, pc;
  logic [19:0] a;
  always #2 pclk = ~pclk;
  // Host drives the wire when enabled, else the device does
  assign dq_in = pins.dq_oe ? pins.dq_out : dq_dev;
  fps_host #(.MIN_GAP_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_o(pins), .dq_in(dq_in),
    .ready_busy_output(ryby));
  fps_flash_model dev (.pins(pins), .supply_low(supply_low), .dq(dq_dev),
    .ready_busy_output(ryby));
  // ****************************************
  // Shared tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Holds the request until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 100);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Starts one flash operation and polls until done
  task op(input logic [3:0] code, input logic [19:0] ad, input logic [15:0] d, input logic alt);
    int i;
    apb(1, fps_pkg::REG_ADDR, {12'h0, ad});
    apb(1, fps_pkg::REG_WDATA, {16'h0, d});
    apb(1, fps_pkg::REG_CTRL, {23'h0, 1'b1, 3'h0, alt, code});
    i = 0;
    do begin apb(0, fps_pkg::REG_STAT, 32'h0); i++; end while (rd[1] !== 1'b1 && i < 900);
    st = rd;
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog sized well beyond the whole sequence
  initial begin
    #400000;
    n_mismatch++;
    final_report;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, fps_pkg::REG_PINS, 32'h0); check(rd, 32'h3);
    apb(0, 8'h40, 32'h0); check(rd, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      pc = dev.prog_cnt;
      op(4'h2, {4'h1, 16'($random(seed))}, 16'($random(seed)), k[0]);
      check({24'h0, st[15:8]}, 32'h80);
      check(dev.prog_cnt, pc + 1);
      check(dev.last_setup, k ? 32'h10 : 32'h40);
    end
    supply_low <= 1'b1;
    op(4'h2, 20'h10010, 16'h1234, 0); check({24'h0, st[15:8]}, 32'h98);
    check(dev.prog_cnt, pc + 1);
    supply_low <= 1'b0;
    op(4'hb, 0, 0, 0); op(4'ha, 0, 0, 0); check({24'h0, st[15:8]}, 32'h80);
    apb(1, fps_pkg::REG_PINS, 32'h2);
    op(4'h2, 20'hf0000, 16'h0, 0); check({24'h0, st[15:8]}, 32'h92);
    op(4'hb, 0, 0, 0);
    apb(1, fps_pkg::REG_PINS, 32'h3);
    $display("test program done");
    a = {4'h2, 16'($random(seed))};
    op(4'h0, a, 16'h0040, 0); op(4'h0, a, 16'h5a5a, 0);
    op(4'h5, a, 0, 0); check({24'h0, st[15:8]}, 32'h84);
    check({31'h0, st[3]}, 32'h1);
    pc = dev.prog_cnt;
    op(4'h2, 20'h30000, 16'h0, 0); check({31'h0, st[2]}, 32'h1);
    check(dev.prog_cnt, pc);
    op(4'hb, 0, 0, 0); check({31'h0, st[2]}, 32'h1);
    op(4'h6, a, 0, 0); check({24'h0, st[15:8]}, 32'h80);
    check(dev.rem, 0);
    op(4'h5, a, 0, 0); check({24'h0, st[15:8]}, 32'h80);
    $display("test suspend done");
    op(4'h7, a, 0, 0); check({24'h0, st[15:8]}, 32'h80);
    check(dev.blk, 1);
    op(4'h2, 20'hf8000, 16'h0, 0); check({24'h0, st[15:8]}, 32'h92);
    op(4'hb, 0, 0, 0);
    op(4'h9, a, 0, 0); check({24'h0, st[15:8]}, 32'h80);
    check(dev.blk, 0);
    op(4'h0, a, 16'h0060, 0); op(4'h0, a, 16'h0000, 0);
    op(4'ha, 0, 0, 0); check({24'h0, st[15:8]}, 32'hb0);
    op(4'hb, 0, 0, 0);
    op(4'h8, a, 0, 0); op(4'h7, a, 0, 0); check({24'h0, st[15:8]}, 32'h92);
    check(dev.blk, 0);
    op(4'hb, 0, 0, 0);
    op(4'h9, a, 0, 0); check({24'h0, st[15:8]}, 32'ha2);
    $display("test locks done");
    final_report;
  end
endmodule

// ### rtl/fps_host.sv
`timescale 1ns/1ps
module fps_host #(
  parameter logic [7:0] CMD_ERASE_SUSP = 8'hb5,
  parameter logic [7:0] CMD_ERASE_RES = 8'hd0,
  parameter logic [7:0] CMD_PROG_SUSP = 8'hb5,
  parameter logic [7:0] CMD_PROG_RES = 8'hd0,
  parameter logic [7:0] CMD_LOCK_SETUP = 8'h60,
  parameter logic [7:0] CMD_BLK_CONFIRM = 8'h01,
  parameter logic [7:0] CMD_PERM_CONFIRM = 8'hf1,
  parameter logic [7:0] CMD_CLR_SETUP = 8'h60,
  parameter logic [7:0] CMD_CLR_CONFIRM = 8'hd0,
  parameter int MIN_GAP_CYCLES = 5000
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output fps_pkg::fps_pins_t flash_o,
  input wire logic [fps_pkg::DATA_W-1:0] dq_in,
  input wire logic ready_busy_output
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (MIN_GAP_CYCLES < 0 || MIN_GAP_CYCLES > 32'h00ffffff) begin : g_bad_gap
    $error("MIN_GAP_CYCLES out of range");
  end

  // ****************************************
  // Declarations
  // ****************************************
  fps_pkg::fps_state_t state;
  fps_pkg::fps_op_t op_q;
  logic alt_q;
  logic [fps_pkg::ADDR_W-1:0] addr_reg;
  logic [fps_pkg::DATA_W-1:0] wdata_reg;
  logic [fps_pkg::DATA_W-1:0] rdata_reg;
  logic [fps_pkg::DATA_W-1:0] wd_q;
  logic [7:0] last_sr;
  logic ctrl_alt;
  logic done;
  logic refused;
  logic wp_reg;
  logic rp_reg;
  logic [7:0] cnt;
  logic [1:0] stp;
  logic [23:0] gap_cnt;
  logic [fps_pkg::DATA_W-1:0] dq_s1, dq_s2;
  logic ryby_s1, ryby_s2;
  logic wr_en, rd_en, start, unmapped, susp_e, susp_p, bad_req;
  logic [1:0] n_wr;
  logic [fps_pkg::DATA_W-1:0] cmd0, cmd1;
  logic poll, one_rd;
  fps_pkg::fps_op_t req_op;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Both stages only: the first stage feeds nothing but the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      ryby_s1 <= 1'b0;
      ryby_s2 <= 1'b0;
    end else if (clk_en) begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      ryby_s1 <= ready_busy_output;
      ryby_s2 <= ryby_s1;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && clk_en;
  assign rd_en = psel && penable && !pwrite;
  assign req_op = fps_pkg::fps_op_t'(pwdata[3:0]);
  assign start = wr_en && paddr == fps_pkg::REG_CTRL && pwdata[fps_pkg::CTRL_START_BIT];
  assign susp_e = last_sr[fps_pkg::SR_ERASE_SUSP];
  assign susp_p = last_sr[fps_pkg::SR_PROG_SUSP];

  // Unmapped offsets answer with an error and read as zero
  always_comb begin
    unmapped = 1'b0;
    prdata = '0;
    case (paddr)
      fps_pkg::REG_CTRL: prdata = {24'h000000, ctrl_alt, 3'h0, op_q};
      fps_pkg::REG_ADDR: prdata = {12'h000, addr_reg};
      fps_pkg::REG_WDATA: prdata = {16'h0000, wdata_reg};
      fps_pkg::REG_STAT: prdata = {16'h0000, last_sr, 4'h0, ryby_s2, refused, done,
                                   state != fps_pkg::ST_IDLE};
      fps_pkg::REG_RDATA: prdata = {16'h0000, rdata_reg};
      fps_pkg::REG_PINS: prdata = {30'h00000000, rp_reg, wp_reg};
      default: unmapped = 1'b1;
    endcase
    if (!rd_en) begin
      prdata = '0;
    end
  end
  assign pslverr = psel && penable && unmapped;

  // Host refuses commands the device would not accept in its suspend mode
  always_comb begin
    bad_req = 1'b0;
    if (susp_p && !(req_op inside {fps_pkg::OP_RAW, fps_pkg::OP_READ,
        fps_pkg::OP_READ_STATUS, fps_pkg::OP_PROG_RES})) begin
      bad_req = 1'b1;
    end
    if (susp_e && (req_op inside {fps_pkg::OP_ERASE_SUSP, fps_pkg::OP_SET_BLK_LOCK,
        fps_pkg::OP_SET_PERM_LOCK, fps_pkg::OP_CLR_LOCKS})) begin
      bad_req = 1'b1;
    end
    if ((susp_e || susp_p) && req_op == fps_pkg::OP_CLR_STATUS) begin
      bad_req = 1'b1;
    end
  end

  // Data registers; write-protect and reset pin levels frozen while anything is suspended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= '0;
      wdata_reg <= '0;
      ctrl_alt <= 1'b0;
      wp_reg <= fps_pkg::PINS_WP_RESET;
      rp_reg <= fps_pkg::PINS_RP_RESET;
    end else if (wr_en) begin
      if (paddr == fps_pkg::REG_ADDR) begin
        addr_reg <= pwdata[fps_pkg::ADDR_W-1:0];
      end
      if (paddr == fps_pkg::REG_WDATA) begin
        wdata_reg <= pwdata[fps_pkg::DATA_W-1:0];
      end
      if (paddr == fps_pkg::REG_CTRL) begin
        ctrl_alt <= pwdata[fps_pkg::CTRL_ALT_BIT];
      end
      if (paddr == fps_pkg::REG_PINS && !susp_e && !susp_p) begin
        wp_reg <= pwdata[fps_pkg::PINS_WP_BIT];
        rp_reg <= pwdata[fps_pkg::PINS_RP_BIT];
      end
    end
  end

  // ****************************************
  // Command sequences
  // ****************************************
  // Writes of each operation, then a status poll, a single read or nothing
  always_comb begin
    n_wr = 2'd0;
    cmd0 = '0;
    cmd1 = '0;
    poll = 1'b0;
    one_rd = 1'b0;
    case (op_q)
      fps_pkg::OP_RAW: begin
        n_wr = 2'd1;
        cmd0 = wdata_reg;
      end
      fps_pkg::OP_READ: one_rd = 1'b1;
      fps_pkg::OP_PROGRAM: begin
        n_wr = 2'd2;
        cmd0 = {8'h00, alt_q ? fps_pkg::CMD_PROG_ALT : fps_pkg::CMD_PROG_SETUP};
        cmd1 = wdata_reg;
        poll = 1'b1;
      end
      fps_pkg::OP_ERASE_SUSP, fps_pkg::OP_PROG_SUSP: begin
        n_wr = 2'd2;
        cmd0 = {8'h00, op_q == fps_pkg::OP_ERASE_SUSP ? CMD_ERASE_SUSP : CMD_PROG_SUSP};
        cmd1 = {8'h00, fps_pkg::CMD_READ_STATUS};
        poll = 1'b1;
      end
      fps_pkg::OP_ERASE_RES, fps_pkg::OP_PROG_RES: begin
        n_wr = 2'd1;
        cmd0 = {8'h00, op_q == fps_pkg::OP_ERASE_RES ? CMD_ERASE_RES : CMD_PROG_RES};
        poll = 1'b1;
      end
      fps_pkg::OP_SET_BLK_LOCK, fps_pkg::OP_SET_PERM_LOCK: begin
        n_wr = 2'd2;
        cmd0 = {8'h00, CMD_LOCK_SETUP};
        cmd1 = {8'h00, op_q == fps_pkg::OP_SET_BLK_LOCK ? CMD_BLK_CONFIRM : CMD_PERM_CONFIRM};
        poll = 1'b1;
      end
      fps_pkg::OP_CLR_LOCKS: begin
        n_wr = 2'd2;
        cmd0 = {8'h00, CMD_CLR_SETUP};
        cmd1 = {8'h00, CMD_CLR_CONFIRM};
        poll = 1'b1;
      end
      fps_pkg::OP_READ_STATUS: begin
        n_wr = 2'd1;
        cmd0 = {8'h00, fps_pkg::CMD_READ_STATUS};
        one_rd = 1'b1;
      end
      fps_pkg::OP_CLR_STATUS: begin
        n_wr = 2'd1;
        cmd0 = {8'h00, fps_pkg::CMD_CLEAR_STATUS};
      end
      default: n_wr = 2'd0;
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // we_n and oe_n compare the whole state against ST_WR and ST_RD, ce_n against both; all are decoded combinationally, not registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= fps_pkg::ST_IDLE;
      op_q <= fps_pkg::OP_RAW;
      alt_q <= 1'b0;
      cnt <= '0;
      stp <= '0;
      wd_q <= '0;
      rdata_reg <= '0;
      last_sr <= '0;
      done <= 1'b0;
      refused <= 1'b0;
    end else if (clk_en) begin
      case (state)
        fps_pkg::ST_IDLE: begin
          if (start) begin
            done <= 1'b0;
            refused <= bad_req;
            if (bad_req) begin
              done <= 1'b1;
            end else begin
              op_q <= req_op;
              alt_q <= pwdata[fps_pkg::CTRL_ALT_BIT];
              stp <= '0;
              state <= fps_pkg::ST_GAP;
            end
          end
        end
        fps_pkg::ST_GAP: begin
          // A suspend waits out the spacing since the last resume
          if (!(op_q inside {fps_pkg::OP_ERASE_SUSP, fps_pkg::OP_PROG_SUSP})
              || gap_cnt == '0) begin
            state <= fps_pkg::ST_NEXT;
          end
        end
        fps_pkg::ST_NEXT: begin
          cnt <= '0;
          if (stp < n_wr) begin
            wd_q <= stp == 2'd0 ? cmd0 : cmd1;
            state <= fps_pkg::ST_WR;
          end else if (poll || one_rd) begin
            state <= fps_pkg::ST_RD;
          end else begin
            done <= 1'b1;
            state <= fps_pkg::ST_IDLE;
          end
        end
        fps_pkg::ST_WR: begin
          cnt <= cnt + 8'd1;
          if (cnt == 8'(fps_pkg::WE_CYC - 1)) begin
            cnt <= '0;
            state <= fps_pkg::ST_WREC; // Device latches on this rising strobe
          end
        end
        fps_pkg::ST_WREC: begin
          cnt <= cnt + 8'd1;
          if (cnt == 8'(fps_pkg::REC_CYC - 1)) begin
            stp <= stp + 2'd1;
            state <= fps_pkg::ST_NEXT;
          end
        end
        fps_pkg::ST_RD: begin
          cnt <= cnt + 8'd1;
          if (cnt == 8'(fps_pkg::ACC_CYC - 1)) begin
            cnt <= '0;
            rdata_reg <= dq_s2;
            if (op_q != fps_pkg::OP_READ) begin
              last_sr <= dq_s2[7:0];
            end
            state <= fps_pkg::ST_RREC;
          end
        end
        fps_pkg::ST_RREC: begin
          // Output enable toggles between polls so status is relatched
          cnt <= cnt + 8'd1;
          if (cnt == 8'(fps_pkg::REC_CYC - 1)) begin
            cnt <= '0;
            if (poll && !rdata_reg[fps_pkg::SR_READY]) begin
              state <= fps_pkg::ST_RD;
            end else begin
              done <= 1'b1;
              state <= fps_pkg::ST_IDLE;
            end
          end
        end
        default: state <= fps_pkg::ST_IDLE;
      endcase
    end
  end

  // Spacing counter, reloaded whenever a resume is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= 24'(fps_pkg::GAP_RESET);
    end else if (clk_en) begin
      if (state == fps_pkg::ST_WR
          && (op_q inside {fps_pkg::OP_ERASE_RES, fps_pkg::OP_PROG_RES})) begin
        gap_cnt <= 24'(MIN_GAP_CYCLES);
      end else if (gap_cnt != '0) begin
        gap_cnt <= gap_cnt - 24'd1;
      end
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_comb begin
    flash_o.ce_n = !(state == fps_pkg::ST_WR || state == fps_pkg::ST_RD);
    flash_o.oe_n = state != fps_pkg::ST_RD;
    flash_o.we_n = state != fps_pkg::ST_WR;
    flash_o.wp_n = wp_reg;
    flash_o.rp_n = rp_reg || susp_p;
    flash_o.addr = addr_reg;
    flash_o.dq_out = wd_q;
    flash_o.dq_oe = state == fps_pkg::ST_WR || state == fps_pkg::ST_WREC;
  end

endmodule

// ### rtl/fps_pkg.sv
// Behaviour
// - Program is a setup write (standard or alternate code) then address and data.
// - Suspend after a finished erase gives read-array; host reads status to confirm.
// - Host holds write-protect steady while an erase is suspended.
// - Suspend after a finished program gives read-array; host reads status to confirm.
// - Host keeps reset high and write-protect steady while a program is suspended.
// - Host avoids suspending again soon after each resume.
// - Setting a lock is setup then confirm; host then checks the lock error flag (the host only polls the ready bit and leaves the flag in the status register).
package fps_pkg;

  // ****************************************
  // Widths and register map
  // ****************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_PINS = 8'h14;
  localparam int CTRL_ALT_BIT = 4;
  localparam int CTRL_START_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_RYBY_BIT = 3;
  localparam int STAT_SR_LSB = 8;
  localparam int PINS_WP_BIT = 0;
  localparam int PINS_RP_BIT = 1;
  localparam logic PINS_WP_RESET = 1'b1;
  localparam logic PINS_RP_RESET = 1'b1;

  // ****************************************
  // Device command bytes and status bits
  // ****************************************
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_PROG_SUSP = 2;

  // ****************************************
  // Strobe timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int T_WE_NS = 60;
  localparam int T_REC_NS = 30;
  localparam int T_ACC_NS = 100;
  localparam int SYNC_STAGES = 2;
  localparam int WE_CYC = (T_WE_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_CYC = (T_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;
  localparam int GAP_RESET = 0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    OP_RAW = 4'h0, OP_READ = 4'h1, OP_PROGRAM = 4'h2, OP_ERASE_SUSP = 4'h3,
    OP_ERASE_RES = 4'h4, OP_PROG_SUSP = 4'h5, OP_PROG_RES = 4'h6,
    OP_SET_BLK_LOCK = 4'h7, OP_SET_PERM_LOCK = 4'h8, OP_CLR_LOCKS = 4'h9,
    OP_READ_STATUS = 4'ha, OP_CLR_STATUS = 4'hb
  } fps_op_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_GAP = 7'h02, ST_NEXT = 7'h04, ST_WR = 7'h08,
    ST_WREC = 7'h10, ST_RD = 7'h20, ST_RREC = 7'h40
  } fps_state_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic wp_n;
    logic rp_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } fps_pins_t;

endpackage
